// *** rtl/irf_pkg.sv ***
/*
  irf_pkg: register map, field positions, reset values, source ids and
  carrier structs for the interrupt request flag block.
  assumes: byte addressing on a 32-bit AXI4-Lite bus, one register per word.
*/
package irf_pkg;

  // ------------------------------------------------------------------
  // register byte addresses
  // ------------------------------------------------------------------
  localparam logic [7:0] ADDR_TIMER_EXT_IRQ_CONTROL  = 8'h88;
  localparam logic [7:0] ADDR_IRQ_ENABLE_A  = 8'hA8;
  localparam logic [7:0] ADDR_IRQ_ENABLE_B  = 8'hB8;  // enable b sits where older cores kept priority
  localparam logic [7:0] ADDR_IRQ_REQUEST_FLAGS_B = 8'hC0;
  localparam logic [7:0] ADDR_TIMER2_CONTROL = 8'hC8;

  // reset values
  localparam logic [7:0] RST_TIMER_EXT_IRQ_CONTROL  = 8'h00;
  localparam logic [7:0] RST_IRQ_ENABLE_A  = 8'h00;
  localparam logic [7:0] RST_IRQ_ENABLE_B  = 8'h00;
  localparam logic [7:0] RST_IRQ_REQUEST_FLAGS_B = 8'h00;
  localparam logic [7:0] RST_TIMER2_CONTROL = 8'h00;
  localparam logic [7:0] RST_PINS  = 8'hFF;   // pins idle high

  // timer_ext_irq_control fields
  localparam int TC_IT0 = 0;
  localparam int TC_IE0 = 1;
  localparam int TC_IT1 = 2;
  localparam int TC_IE1 = 3;
  localparam int TC_TF0 = 5;
  localparam int TC_TF1 = 7;

  // irq_request_flags_b fields; ext irq k (2..6) sits at IR_EXT_IRQ_TWO_FLAG + k - 2
  localparam int IR_ADC  = 0;
  localparam int IR_EXT_IRQ_TWO_FLAG = 1;
  localparam int IR_TF2  = 6;
  localparam int IR_TIMER_TWO_RELOAD_FLAG = 7;

  // timer2_control fields
  localparam int T2_EXT_IRQ_TWO_EDGE_SEL = 5;
  localparam int T2_EXT_IRQ_THREE_EDGE_SEL = 6;

  // irq_enable_a fields
  localparam int E0_EX0 = 0;
  localparam int E0_ET0 = 1;
  localparam int E0_EX1 = 2;
  localparam int E0_ET1 = 3;
  localparam int E0_ES  = 4;
  localparam int E0_ET2 = 5;
  localparam int E0_EAL = 7;

  // irq_enable_b fields; enable k (2..6) sits at E1_EX2 + k - 2
  localparam int E1_EADC  = 0;
  localparam int E1_EX2   = 1;
  localparam int E1_TIMER_TWO_RELOAD_ENABLE = 7;

  // pin vector positions
  localparam int PIN_EXT_IRQ_PIN_ZERO = 0;
  localparam int PIN_EXT_IRQ_PIN_ONE = 1;
  localparam int PIN_EXT_IRQ_PIN_TWO = 2;
  localparam int PIN_EXT_IRQ_PIN_THREE = 3;
  localparam int PIN_INT4 = 4;
  localparam int PIN_TIMER_TWO_RELOAD_INPUT = 7;

  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  localparam int IRF_NSRC = 12;

  typedef enum logic [3:0] {
    IRF_SRC_EXT0, IRF_SRC_TMR0, IRF_SRC_EXT1, IRF_SRC_TMR1, IRF_SRC_SERIAL,
    IRF_SRC_TMR2, IRF_SRC_CONV, IRF_SRC_EXT2, IRF_SRC_EXT3, IRF_SRC_EXT4,
    IRF_SRC_EXT5, IRF_SRC_EXT6
  } irf_src_e;

  typedef enum logic [2:0] {
    IRF_SEL_NONE, IRF_SEL_TIMER_EXT_IRQ_CONTROL, IRF_SEL_IRQ_ENABLE_A, IRF_SEL_IRQ_ENABLE_B, IRF_SEL_IRQ_REQUEST_FLAGS_B, IRF_SEL_TIMER2_CONTROL
  } irf_sel_e;

  // external pins, ext_irq_pin_zero in bit 0, reload input in bit 7
  typedef struct packed {
    logic timer_two_reload_input;
    logic int6;
    logic int5;
    logic int4;
    logic ext_irq_pin_three;
    logic ext_irq_pin_two;
    logic ext_irq_pin_one;
    logic ext_irq_pin_zero;
  } irf_pins_s;

  // one-cycle event strobes from peripherals on aclk
  typedef struct packed {
    logic       tf0;
    logic       tf1;
    logic       tf2;
    logic       conv_done;
    logic       serial;
    logic [4:0] cmp;
  } irf_evt_s;

endpackage

// *** rtl/irf_core.sv ***
/*
  irf_core: interrupt request flags, external edge/level detection, vector
  clears, individual and global enables, AXI4-Lite register slave.
  assumes: aclk is the machine-cycle clock, ce freezes everything but the serial request, peripheral
  strobes and the vector acknowledge are synchronous to aclk, pins are not.
*/
// The implementer's own choice: the AXI4-Lite interface to the registers.
`timescale 1ns/1ps

module irf_core
  import irf_pkg::*;
#(
  parameter int ADDR_W = 8
) (
  input  logic                        aclk,
  input  logic                        aresetn,
  input  logic                        ce,
  input  irf_pkg::irf_pins_s          pins,
  input  irf_pkg::irf_evt_s           evt,
  input  logic                        vec_ack,
  input  irf_pkg::irf_src_e           vec_id,
  output logic [irf_pkg::IRF_NSRC-1:0] irq_req,
  input  logic [ADDR_W-1:0]           awaddr,
  input  logic                        awvalid,
  output logic                        awready,
  input  logic [31:0]                 wdata,
  input  logic [3:0]                  wstrb,
  input  logic                        wvalid,
  output logic                        wready,
  output logic [1:0]                  bresp,
  output logic                        bvalid,
  input  logic                        bready,
  input  logic [ADDR_W-1:0]           araddr,
  input  logic                        arvalid,
  output logic                        arready,
  output logic [31:0]                 rdata,
  output logic [1:0]                  rresp,
  output logic                        rvalid,
  input  logic                        rready
);

  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  // ------------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------------
  // flag update: hardware set wins over software write and vector clear
  function automatic logic upd(input logic cur, input logic set, input logic clr,
                               input logic we, input logic wb);
    upd = set | (we ? wb : (cur & ~clr));
  endfunction

  function automatic irf_sel_e dec(input logic [ADDR_W-1:0] a);
    if (a == ADDR_W'(ADDR_TIMER_EXT_IRQ_CONTROL)) begin
      dec = IRF_SEL_TIMER_EXT_IRQ_CONTROL;
    end else if (a == ADDR_W'(ADDR_IRQ_ENABLE_A)) begin
      dec = IRF_SEL_IRQ_ENABLE_A;
    end else if (a == ADDR_W'(ADDR_IRQ_ENABLE_B)) begin
      dec = IRF_SEL_IRQ_ENABLE_B;
    end else if (a == ADDR_W'(ADDR_IRQ_REQUEST_FLAGS_B)) begin
      dec = IRF_SEL_IRQ_REQUEST_FLAGS_B;
    end else if (a == ADDR_W'(ADDR_TIMER2_CONTROL)) begin
      dec = IRF_SEL_TIMER2_CONTROL;
    end else begin
      dec = IRF_SEL_NONE;
    end
  endfunction

  function automatic logic vclr(input logic ack, input irf_src_e id, input irf_src_e s);
    vclr = ack && (id == s);
  endfunction

  // ------------------------------------------------------------------
  // pin synchroniser and edge detection
  // ------------------------------------------------------------------
  logic [7:0] pin_s1_ff;
  logic [7:0] pin_s2_ff;
  logic [7:0] pin_prev_ff;
  logic [7:0] p_fall;
  logic [7:0] p_rise;

  // two flops against metastability, third holds last cycle's sample
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pin_s1_ff   <= RST_PINS;
      pin_s2_ff   <= RST_PINS;
      pin_prev_ff <= RST_PINS;
    end else if (ce) begin
      pin_s1_ff   <= pins;
      pin_s2_ff   <= pin_s1_ff;
      pin_prev_ff <= pin_s2_ff;
    end
  end

  // one request per edge: sample now against sample one cycle ago
  assign p_fall = pin_prev_ff & ~pin_s2_ff;
  assign p_rise = ~pin_prev_ff & pin_s2_ff;

  // ------------------------------------------------------------------
  // AXI4-Lite write channel
  // ------------------------------------------------------------------
  logic              aw_ff;
  logic              w_ff;
  logic [ADDR_W-1:0] awaddr_ff;
  logic [7:0]        wbyte_ff;
  logic              wlane_ff;
  logic              bvalid_ff;
  logic [1:0]        bresp_ff;
  logic              wr_go;
  irf_sel_e          wsel;

  // address and data taken in either order, one write in flight
  assign awready = ce & ~aw_ff & ~bvalid_ff;
  assign wready  = ce & ~w_ff & ~bvalid_ff;
  assign wr_go   = aw_ff & w_ff & ~bvalid_ff;
  assign wsel    = dec(awaddr_ff);
  assign bvalid  = bvalid_ff;
  assign bresp   = bresp_ff;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_ff     <= 1'b0;
      w_ff      <= 1'b0;
      awaddr_ff <= '0;
      wbyte_ff  <= 8'h00;
      wlane_ff  <= 1'b0;
      bvalid_ff <= 1'b0;
      bresp_ff  <= RESP_OKAY;
    end else if (ce) begin
      if (awvalid && awready) begin
        aw_ff     <= 1'b1;
        awaddr_ff <= awaddr;
      end
      if (wvalid && wready) begin
        w_ff     <= 1'b1;
        wbyte_ff <= wdata[7:0];
        wlane_ff <= wstrb[0];  // only byte lane 0 carries register bits
      end
      if (wr_go) begin
        aw_ff     <= 1'b0;
        w_ff      <= 1'b0;
        bvalid_ff <= 1'b1;
        bresp_ff  <= (wsel == IRF_SEL_NONE) ? RESP_SLVERR : RESP_OKAY;
      end else if (bvalid_ff && bready) begin
        bvalid_ff <= 1'b0;
      end
    end
  end

  logic we_timer_ext_irq_control;
  logic we_irq_request_flags_b;
  logic we_timer2_control;
  logic we_irq_enable_a;
  logic we_irq_enable_b;

  assign we_timer_ext_irq_control  = wr_go & wlane_ff & (wsel == IRF_SEL_TIMER_EXT_IRQ_CONTROL);
  assign we_irq_request_flags_b = wr_go & wlane_ff & (wsel == IRF_SEL_IRQ_REQUEST_FLAGS_B);
  assign we_timer2_control = wr_go & wlane_ff & (wsel == IRF_SEL_TIMER2_CONTROL);
  assign we_irq_enable_a  = wr_go & wlane_ff & (wsel == IRF_SEL_IRQ_ENABLE_A);
  assign we_irq_enable_b  = wr_go & wlane_ff & (wsel == IRF_SEL_IRQ_ENABLE_B);

  // ------------------------------------------------------------------
  // control and enable registers
  // ------------------------------------------------------------------
  logic [7:0] timer2_control_ff;
  logic [7:0] irq_enable_a_ff;
  logic [7:0] irq_enable_b_ff;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      timer2_control_ff <= RST_TIMER2_CONTROL;
      irq_enable_a_ff  <= RST_IRQ_ENABLE_A;
      irq_enable_b_ff  <= RST_IRQ_ENABLE_B;
    end else if (ce) begin
      if (we_timer2_control) timer2_control_ff <= wbyte_ff;
      if (we_irq_enable_a) irq_enable_a_ff <= wbyte_ff;
      if (we_irq_enable_b) irq_enable_b_ff <= wbyte_ff;
    end
  end

  // ------------------------------------------------------------------
  // timer_ext_irq_control flags
  // ------------------------------------------------------------------
  logic [7:0] timer_ext_irq_control_ff;
  logic [7:0] nxt_timer_ext_irq_control;
  logic       edge0;
  logic       edge1;

  assign edge0 = timer_ext_irq_control_ff[TC_IT0] & p_fall[PIN_EXT_IRQ_PIN_ZERO];
  assign edge1 = timer_ext_irq_control_ff[TC_IT1] & p_fall[PIN_EXT_IRQ_PIN_ONE];

  // run bits are plain storage; level mode ignores software and follows the pin
  // the type bit being written decides, so a write that selects edge mode and
  // sets the flag in one go raises the request as software intended
  always_comb begin
    nxt_timer_ext_irq_control = we_timer_ext_irq_control ? wbyte_ff : timer_ext_irq_control_ff;
    nxt_timer_ext_irq_control[TC_IE0] = nxt_timer_ext_irq_control[TC_IT0] ?
      upd(timer_ext_irq_control_ff[TC_IE0], edge0, vclr(vec_ack, vec_id, IRF_SRC_EXT0),
          we_timer_ext_irq_control, wbyte_ff[TC_IE0]) : ~pin_s2_ff[PIN_EXT_IRQ_PIN_ZERO];
    nxt_timer_ext_irq_control[TC_IE1] = nxt_timer_ext_irq_control[TC_IT1] ?
      upd(timer_ext_irq_control_ff[TC_IE1], edge1, vclr(vec_ack, vec_id, IRF_SRC_EXT1),
          we_timer_ext_irq_control, wbyte_ff[TC_IE1]) : ~pin_s2_ff[PIN_EXT_IRQ_PIN_ONE];
    nxt_timer_ext_irq_control[TC_TF0] = upd(timer_ext_irq_control_ff[TC_TF0], evt.tf0,
                           vclr(vec_ack, vec_id, IRF_SRC_TMR0), we_timer_ext_irq_control, wbyte_ff[TC_TF0]);
    nxt_timer_ext_irq_control[TC_TF1] = upd(timer_ext_irq_control_ff[TC_TF1], evt.tf1,
                           vclr(vec_ack, vec_id, IRF_SRC_TMR1), we_timer_ext_irq_control, wbyte_ff[TC_TF1]);
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      timer_ext_irq_control_ff <= RST_TIMER_EXT_IRQ_CONTROL;
    end else if (ce) begin
      timer_ext_irq_control_ff <= nxt_timer_ext_irq_control;
    end
  end

  // ------------------------------------------------------------------
  // irq_request_flags_b flags
  // ------------------------------------------------------------------
  logic [7:0] irq_request_flags_b_ff;
  logic [7:0] nxt_irq_request_flags_b;
  logic       set2;
  logic       set3;

  // selectable edge on ext irq 2/3, compare channels join in regardless of mode
  assign set2 = (timer2_control_ff[T2_EXT_IRQ_TWO_EDGE_SEL] ? p_rise[PIN_EXT_IRQ_PIN_TWO] : p_fall[PIN_EXT_IRQ_PIN_TWO])
                | evt.cmp[4];
  assign set3 = (timer2_control_ff[T2_EXT_IRQ_THREE_EDGE_SEL] ? p_rise[PIN_EXT_IRQ_PIN_THREE] : p_fall[PIN_EXT_IRQ_PIN_THREE])
                | evt.cmp[0];

  always_comb begin
    nxt_irq_request_flags_b = irq_request_flags_b_ff;
    // conversion strobe arrives ahead of the result; one cycle to the flag
    nxt_irq_request_flags_b[IR_ADC] = upd(irq_request_flags_b_ff[IR_ADC], evt.conv_done, 1'b0,
                            we_irq_request_flags_b, wbyte_ff[IR_ADC]);
    nxt_irq_request_flags_b[IR_EXT_IRQ_TWO_FLAG] = upd(irq_request_flags_b_ff[IR_EXT_IRQ_TWO_FLAG], set2,
                             vclr(vec_ack, vec_id, IRF_SRC_EXT2), we_irq_request_flags_b, wbyte_ff[IR_EXT_IRQ_TWO_FLAG]);
    nxt_irq_request_flags_b[IR_EXT_IRQ_TWO_FLAG+1] = upd(irq_request_flags_b_ff[IR_EXT_IRQ_TWO_FLAG+1], set3,
                               vclr(vec_ack, vec_id, IRF_SRC_EXT3), we_irq_request_flags_b,
                               wbyte_ff[IR_EXT_IRQ_TWO_FLAG+1]);
    for (int k = 0; k < 3; k++) begin
      nxt_irq_request_flags_b[IR_EXT_IRQ_TWO_FLAG+2+k] = upd(irq_request_flags_b_ff[IR_EXT_IRQ_TWO_FLAG+2+k],
                                   p_rise[PIN_INT4+k] | evt.cmp[1+k],
                                   vclr(vec_ack, vec_id, irf_src_e'(4'(IRF_SRC_EXT4) + 4'(k))),
                                   we_irq_request_flags_b, wbyte_ff[IR_EXT_IRQ_TWO_FLAG+2+k]);
    end
    nxt_irq_request_flags_b[IR_TF2] = upd(irq_request_flags_b_ff[IR_TF2], evt.tf2, 1'b0,
                            we_irq_request_flags_b, wbyte_ff[IR_TF2]);
    nxt_irq_request_flags_b[IR_TIMER_TWO_RELOAD_FLAG] = upd(irq_request_flags_b_ff[IR_TIMER_TWO_RELOAD_FLAG],
                             irq_enable_b_ff[E1_TIMER_TWO_RELOAD_ENABLE] & p_fall[PIN_TIMER_TWO_RELOAD_INPUT], 1'b0,
                             we_irq_request_flags_b, wbyte_ff[IR_TIMER_TWO_RELOAD_FLAG]);
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      irq_request_flags_b_ff <= RST_IRQ_REQUEST_FLAGS_B;
    end else if (ce) begin
      irq_request_flags_b_ff <= nxt_irq_request_flags_b;
    end
  end

  // ------------------------------------------------------------------
  // gated requests toward the vectoring logic
  // ------------------------------------------------------------------
  // global bit masks everything, flags keep collecting meanwhile
  always_comb begin
    irq_req = '0;
    irq_req[IRF_SRC_EXT0]   = timer_ext_irq_control_ff[TC_IE0] & irq_enable_a_ff[E0_EX0];
    irq_req[IRF_SRC_TMR0]   = timer_ext_irq_control_ff[TC_TF0] & irq_enable_a_ff[E0_ET0];
    irq_req[IRF_SRC_EXT1]   = timer_ext_irq_control_ff[TC_IE1] & irq_enable_a_ff[E0_EX1];
    irq_req[IRF_SRC_TMR1]   = timer_ext_irq_control_ff[TC_TF1] & irq_enable_a_ff[E0_ET1];
    irq_req[IRF_SRC_SERIAL] = evt.serial & irq_enable_a_ff[E0_ES];
    irq_req[IRF_SRC_TMR2]   = (irq_request_flags_b_ff[IR_TF2] | irq_request_flags_b_ff[IR_TIMER_TWO_RELOAD_FLAG]) & irq_enable_a_ff[E0_ET2];
    irq_req[IRF_SRC_CONV]   = irq_request_flags_b_ff[IR_ADC] & irq_enable_b_ff[E1_EADC];
    for (int k = 0; k < 5; k++) begin
      irq_req[4'(IRF_SRC_EXT2) + 4'(k)] = irq_request_flags_b_ff[IR_EXT_IRQ_TWO_FLAG+k] & irq_enable_b_ff[E1_EX2+k];
    end
    if (!irq_enable_a_ff[E0_EAL]) irq_req = '0;
  end

  // ------------------------------------------------------------------
  // AXI4-Lite read channel
  // ------------------------------------------------------------------
  logic        rvalid_ff;
  logic [31:0] rdata_ff;
  logic [1:0]  rresp_ff;
  logic [7:0]  rd_byte;
  irf_sel_e    rsel;

  assign arready = ce & ~rvalid_ff;
  assign rvalid  = rvalid_ff;
  assign rdata   = rdata_ff;
  assign rresp   = rresp_ff;
  assign rsel    = dec(araddr);

  always_comb begin
    case (rsel)
      IRF_SEL_TIMER_EXT_IRQ_CONTROL:  rd_byte = timer_ext_irq_control_ff;
      IRF_SEL_IRQ_ENABLE_A:  rd_byte = irq_enable_a_ff;
      IRF_SEL_IRQ_ENABLE_B:  rd_byte = irq_enable_b_ff;
      IRF_SEL_IRQ_REQUEST_FLAGS_B: rd_byte = irq_request_flags_b_ff;
      IRF_SEL_TIMER2_CONTROL: rd_byte = timer2_control_ff;
      default:       rd_byte = 8'h00;
    endcase
  end

  // unmapped reads answer zero with slverr
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_ff <= 1'b0;
      rdata_ff  <= 32'h0000_0000;
      rresp_ff  <= RESP_OKAY;
    end else if (ce) begin
      if (arvalid && arready) begin
        rvalid_ff <= 1'b1;
        rdata_ff  <= {24'h00_0000, rd_byte};
        rresp_ff  <= (rsel == IRF_SEL_NONE) ? RESP_SLVERR : RESP_OKAY;
      end else if (rvalid_ff && rready) begin
        rvalid_ff <= 1'b0;
      end
    end
  end

  // ------------------------------------------------------------------
  // assertions
  // ------------------------------------------------------------------
  ext0_edge_set_a: assert property (ce && edge0 |=> timer_ext_irq_control_ff[TC_IE0])
    else $error("ext irq 0 edge did not set flag");
  ext0_level_a: assert property (ce && !nxt_timer_ext_irq_control[TC_IT0]
      |=> timer_ext_irq_control_ff[TC_IE0] == !$past(pin_s2_ff[PIN_EXT_IRQ_PIN_ZERO]))
    else $error("level flag does not follow pin");
  tmr0_vec_clr_a: assert property (ce && vclr(vec_ack, vec_id, IRF_SRC_TMR0)
      && !evt.tf0 && !we_timer_ext_irq_control |=> !timer_ext_irq_control_ff[TC_TF0])
    else $error("timer 0 flag not cleared on vector");
  ext2_rise_a: assert property (ce && timer2_control_ff[T2_EXT_IRQ_TWO_EDGE_SEL] && $rose(pin_s2_ff[PIN_EXT_IRQ_PIN_TWO])
      |=> irq_request_flags_b_ff[IR_EXT_IRQ_TWO_FLAG])
    else $error("ext irq 2 rising edge missed");
  ext3_cmp_a: assert property (ce && evt.cmp[0] |=> irq_request_flags_b_ff[IR_EXT_IRQ_TWO_FLAG+1])
    else $error("compare 0 did not set ext irq 3");
  ext2_cmp_a: assert property (ce && evt.cmp[4] |=> irq_request_flags_b_ff[IR_EXT_IRQ_TWO_FLAG])
    else $error("compare 4 did not set ext irq 2");
  tmr2_hold_a: assert property (ce && irq_request_flags_b_ff[IR_TF2] && !we_irq_request_flags_b
      ##1 ce && !we_irq_request_flags_b |=> irq_request_flags_b_ff[IR_TF2])
    else $error("timer 2 flag cleared by hardware");
  reload_flag_a: assert property (ce && irq_enable_b_ff[E1_TIMER_TWO_RELOAD_ENABLE] && p_fall[PIN_TIMER_TWO_RELOAD_INPUT]
      |=> irq_request_flags_b_ff[IR_TIMER_TWO_RELOAD_FLAG])
    else $error("reload edge did not set flag");
  conv_keep_a: assert property (irq_request_flags_b_ff[IR_ADC] && !we_irq_request_flags_b |=> irq_request_flags_b_ff[IR_ADC])
    else $error("conversion flag lost without write");
  global_gate_a: assert property (!irq_enable_a_ff[E0_EAL] |-> irq_req == '0)
    else $error("request passed with global enable low");
  ext4_rise_a: assert property (ce && p_rise[PIN_INT4] |=> irq_request_flags_b_ff[IR_EXT_IRQ_TWO_FLAG+2])
    else $error("ext irq 4 rising edge missed");
  write_resp_a: assert property (ce && wr_go |=> bvalid)
    else $error("write response missing");

  level_mode_c: cover property (!timer_ext_irq_control_ff[TC_IT0] && timer_ext_irq_control_ff[TC_IE0]);
  ext2_vec_c: cover property (irq_request_flags_b_ff[IR_EXT_IRQ_TWO_FLAG] && vclr(vec_ack, vec_id, IRF_SRC_EXT2)
      ##1 !irq_request_flags_b_ff[IR_EXT_IRQ_TWO_FLAG]);
  tmr2_req_c: cover property (irq_req[IRF_SRC_TMR2]);
  slverr_c: cover property (rvalid && rresp == RESP_SLVERR);

endmodule

// *** verification/irf_far.sv ***
/*
  irf_far: model of the far side of irf_core: pins, peripheral strobes and
  the cpu vectoring pulse.
  assumes: the bench calls its tasks one at a time; pins idle high.
*/
`timescale 1ns/1ps
module irf_far
  import irf_pkg::*;
(
  input  wire logic         aclk,
  output irf_pkg::irf_pins_s pins,
  output irf_pkg::irf_evt_s  evt,
  output logic              vec_ack,
  output irf_pkg::irf_src_e  vec_id
);
  // ----------------
  // drivers
  // ----------------
  // idle state: pins high, no strobe, no vector
  initial begin
    pins = RST_PINS;
    evt = '0;
    vec_ack = 1'b0;
    vec_id = IRF_SRC_EXT0;
  end

  // pins are asynchronous in the chip; here they move after an edge
  task automatic pin(input int i, input logic v);
    @(posedge aclk);
    pins[i] <= v;
  endtask

  // peripheral strobes last exactly one cycle
  task automatic pulse(input irf_evt_s e);
    @(posedge aclk);
    evt <= e;
    @(posedge aclk);
    evt <= '0;
  endtask

  // one-cycle vectoring acknowledge for a source
  task automatic vector(input irf_src_e s);
    @(posedge aclk);
    vec_id <= s;
    vec_ack <= 1'b1;
    @(posedge aclk);
    vec_ack <= 1'b0;
  endtask
endmodule

// *** verification/tb_irq_request_flags.sv ***
/*
  tb_irq_request_flags: self-checking bench for irf_core with a register model.
  assumes: irf_far drives pins, strobes and vectoring; ce stays high.
*/
`timescale 1ns/1ps
module tb_irq_request_flags;
  import irf_pkg::*;
  logic        aclk, aresetn, ce, vec_ack, awvalid, wvalid, bready, arvalid, rready;
  logic        awready, wready, bvalid, arready, rvalid;
  logic [7:0]  awaddr, araddr;
  logic [31:0] wdata, rdata, seed;
  logic [3:0]  wstrb;
  logic [1:0]  bresp, rresp;
  logic [11:0] irq_req;
  irf_pins_s   pins;
  irf_evt_s    evt;
  irf_src_e    vec_id;
  int          error_cnt, checked;
  logic [7:0]  adr [5] = '{ADDR_TIMER_EXT_IRQ_CONTROL, ADDR_IRQ_ENABLE_A, ADDR_IRQ_ENABLE_B, ADDR_IRQ_REQUEST_FLAGS_B, ADDR_TIMER2_CONTROL};
  logic [7:0]  mdl [5] = '{default: 8'h00};  // expected register contents

  irf_far far (.aclk(aclk), .pins(pins), .evt(evt), .vec_ack(vec_ack), .vec_id(vec_id));
  irf_core #(.ADDR_W(8)) dut (.aclk(aclk), .aresetn(aresetn), .ce(ce), .pins(pins),
    .evt(evt), .vec_ack(vec_ack), .vec_id(vec_id), .irq_req(irq_req), .awaddr(awaddr),
    .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid),
    .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr),
    .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid),
    .rready(rready));

  initial begin
    aclk = 1'b0;
    forever #2 aclk = ~aclk;
  end

  // ----------------
  // helpers
  // ----------------
  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  task automatic give_verdict();
    $display("checks %0d errors %0d", checked, error_cnt);
    if (error_cnt == 0 && checked > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      error_cnt++;
      $display("ERROR %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic tmo();
    error_cnt++;
    $display("ERROR bus wait expected answer seen none");
    give_verdict();
  endtask

  // ready and answers are read mid-cycle, acted on at the next rising edge
  task automatic axw(input logic [7:0] a, input logic [7:0] d, input logic [1:0] er);
    int         n;
    logic       aw, w, b;
    logic [1:0] rs;
    @(posedge aclk);
    awaddr <= a;
    wdata <= {24'h0, d};
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    for (n = 0; n < 40; n++) begin
      @(negedge aclk);
      aw = awvalid & awready;
      w = wvalid & wready;
      b = bvalid;
      rs = bresp;
      @(posedge aclk);
      if (aw) awvalid <= 1'b0;
      if (w) wvalid <= 1'b0;
      if (b) break;
    end
    bready <= 1'b0;
    if (n == 40) tmo();
    chk("bresp", 32'(rs), 32'(er));
  endtask

  task automatic axr(input logic [7:0] a, output logic [31:0] d, output logic [1:0] rs);
    int   n;
    logic at, b;
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    for (n = 0; n < 40; n++) begin
      @(negedge aclk);
      at = arvalid & arready;
      b = rvalid;
      d = rdata;
      rs = rresp;
      @(posedge aclk);
      if (at) arvalid <= 1'b0;
      if (b) break;
    end
    rready <= 1'b0;
    if (n == 40) tmo();
  endtask

  // level-mode flags of ext irq 0/1 follow the idle-high pins, so read 0
  task automatic wr(input int r, input logic [7:0] v);
    axw(adr[r], v, RESP_OKAY);
    mdl[r] = (r == 0) ? v & {4'hF, v[2], 1'b1, v[0], 1'b1} : v;
  endtask

  // every register and the request vector against the model
  task automatic chk_all();
    logic [31:0] d;
    logic [1:0]  rs;
    logic [11:0] ei;
    for (int r = 0; r < 5; r++) begin
      axr(adr[r], d, rs);
      chk($sformatf("reg%0d", r), d, {24'h0, mdl[r]});
      chk("rresp", 32'(rs), 32'(RESP_OKAY));
    end
    ei = {mdl[3][5:1] & mdl[2][5:1], mdl[3][0] & mdl[2][0], |mdl[3][7:6] & mdl[1][5], 1'b0,
          mdl[0][7] & mdl[1][3], mdl[0][3] & mdl[1][2], mdl[0][5] & mdl[1][1],
          mdl[0][1] & mdl[1][0]};
    if (!mdl[1][7]) ei = '0;
    @(negedge aclk);
    chk("irq_req", {20'h0, irq_req}, {20'h0, ei});
  endtask

  // ----------------
  // main sequence
  // ----------------
  initial begin
    logic [31:0] d;
    logic [1:0]  rs;
    int          b;
    seed = 32'h9DF38903;
    {aresetn, awvalid, wvalid, bready, arvalid, rready} = '0;
    {error_cnt, checked, awaddr, araddr, wdata} = '0;
    ce = 1'b1;
    wstrb = 4'hF;
    repeat (10) @(posedge aclk);
    aresetn <= 1'b1;
    chk_all();
    axr(8'h04, d, rs);
    chk("unmapped data", d, 32'h0);
    chk("unmapped resp", 32'(rs), 32'(RESP_SLVERR));
    axw(8'h04, 8'h5A, RESP_SLVERR);
    wr(1, 8'hBF);
    wr(2, 8'h7F);
    far.pulse('{tf0: 1'b1, tf1: 1'b1, default: '0});
    mdl[0] |= 8'hA0;
    chk_all();
    wr(1, 8'h3F);
    chk_all();
    wr(1, 8'hBF);
    far.vector(IRF_SRC_TMR0);
    far.vector(IRF_SRC_TMR1);
    mdl[0] &= 8'h5F;
    chk_all();
    // ext irq 0/1: edge mode then level mode
    for (int k = 0; k < 2; k++) begin
      b = 2 * k;
      wr(0, 8'h1 << b);
      far.pin(k, 1'b0);
      repeat (5) @(posedge aclk);
      mdl[0][b+1] = 1'b1;
      chk_all();
      far.vector(irf_src_e'(b));
      mdl[0][b+1] = 1'b0;
      chk_all();
      far.pin(k, 1'b1);
      wr(0, 8'h00);
      far.pin(k, 1'b0);
      repeat (5) @(posedge aclk);
      far.vector(irf_src_e'(b));
      mdl[0][b+1] = 1'b1;
      chk_all();
      far.pin(k, 1'b1);
      repeat (5) @(posedge aclk);
      wr(0, 8'h2 << b);
      chk_all();
    end
    // ext irq 2..6: falling then rising pin, each edge select
    for (int k = 2; k < 7; k++) begin
      for (int fr = (k > 3); fr < 2; fr++) begin
        wr(4, (k < 4) ? 8'(fr << (k + 3)) : 8'h00);
        for (int s = 0; s < 2; s++) begin
          far.pin(k, s[0]);
          repeat (5) @(posedge aclk);
          if (s == fr) mdl[3][k-1] = 1'b1;
          chk_all();
          far.vector(irf_src_e'(k + 5));
          mdl[3][k-1] = 1'b0;
          chk_all();
        end
      end
    end
    // compare channels 0..4
    for (int c = 0; c < 5; c++) begin
      b = (c == 4) ? 1 : c + 2;
      far.pulse('{cmp: 5'h1 << c, default: '0});
      mdl[3][b] = 1'b1;
      chk_all();
      far.vector(irf_src_e'(b + 6));
      mdl[3][b] = 1'b0;
      chk_all();
    end
    // conversion and timer 2 flags survive vectoring
    far.pulse('{conv_done: 1'b1, tf2: 1'b1, default: '0});
    mdl[3] |= 8'h41;
    far.vector(IRF_SRC_CONV);
    far.vector(IRF_SRC_TMR2);
    chk_all();
    wr(3, 8'h00);
    chk_all();
    for (int en = 0; en < 2; en++) begin
      wr(2, en[0] ? 8'hFF : 8'h7F);
      far.pin(7, 1'b0);
      repeat (5) @(posedge aclk);
      far.vector(IRF_SRC_TMR2);
      mdl[3][7] = en[0];
      chk_all();
      far.pin(7, 1'b1);
    end
    // random software writes; the watchdog bit of enable a is left out
    for (int i = 0; i < 4; i++) begin
      for (int r = 0; r < 5; r++) begin
        d = xs();
        wr(r, (r == 1) ? d[7:0] & 8'hBF : d[7:0]);
      end
      chk_all();
    end
    give_verdict();
  end
endmodule
